// ===== rtl/rcf_pkg.sv
/*
 * shared constants of the stored-setting and debug-route command handler.
 * assumes nothing beyond a single clock domain.
 */
package rcf_pkg;
	// command codes
	localparam logic [7:0] CMD_SET_WRITE = 8'h12;
	localparam logic [7:0] CMD_SET_COUNT = 8'h13;
	localparam logic [7:0] CMD_SET_READ = 8'h14;
	localparam logic [7:0] CMD_RESERVED = 8'h15;
	localparam logic [7:0] CMD_FIELD_ON = 8'h16;
	localparam logic [7:0] CMD_FIELD_OFF = 8'h17;
	localparam logic [7:0] CMD_DBG_ROUTE = 8'h18;
	// selector ranges
	localparam logic [7:0] TX_CFG_FIRST = 8'h00;
	localparam logic [7:0] TX_CFG_LAST = 8'h1c;
	localparam logic [7:0] RX_CFG_FIRST = 8'h80;
	localparam logic [7:0] RX_CFG_LAST = 8'h9c;
	// payload limits
	localparam int WR_ELEM_MAX = 42;
	localparam int ELEM_BYTES = 6;
	localparam int RD_PAIR_MAX = 39;
	localparam int ROUTE_MAX = 4;
	// field-enable parameter bits
	localparam int FLD_NO_COLL_BIT = 0;
	localparam int FLD_ACTIVE_BIT = 1;
	// routing byte fields
	localparam int RT_SIG_LSB = 0;
	localparam int RT_PIN_LSB = 4;
	localparam logic [3:0] SIG_CARRIER = 4'h8;
	localparam logic [3:0] PIN_COUNT = 4'h4;
	// debug pin order: 0 irq, 1 aux one, 2 aux two, 3 general output
	localparam int DBG_PINS = 4;
	// signal groups
	localparam logic [7:0] GRP_CLOCK = 8'h01;
	localparam logic [7:0] GRP_TX_ENC = 8'h1b;
	localparam logic [7:0] GRP_TIMER = 8'h1d;
	localparam logic [7:0] GRP_CARD = 8'h30;
	localparam logic [7:0] GRP_TRX = 8'h58;
	localparam logic [7:0] GRP_RX_DATA = 8'h70;
	localparam logic [7:0] GRP_RX_ERR = 8'h73;
	// transmit encoder group codes
	localparam logic [3:0] TXE_ENVELOPE = 4'h1;
	localparam logic [3:0] TXE_IRQ = 4'h0;
	// reset values
	localparam logic [7:0] GROUP_RESET = 8'h00;
	// parser states, gray in the order listed
	typedef enum logic [2:0] {
		S_CMD = 3'b000,
		S_WRITE = 3'b001,
		S_PARAM = 3'b011,
		S_ROUTE = 3'b010,
		S_COUNT = 3'b110,
		S_READ = 3'b111,
		S_DRAIN = 3'b101
	} rcf_state_t;
	// is a selector inside the transmitter or receiver range
	function automatic logic cfgIdOk(input logic [7:0] id);
		cfgIdOk = (id >= TX_CFG_FIRST && id <= TX_CFG_LAST) ||
			(id >= RX_CFG_FIRST && id <= RX_CFG_LAST);
	endfunction
endpackage

// ===== rtl/rcf_link_if.sv
/*
 * byte link between the host end and the device end of the command handler.
 * assumes both ends share clk; serial framing is below this level.
 */
`timescale 1ns/1ps
interface rcf_link_if;
	logic hValid; // host byte offered
	logic [7:0] hByte; // host byte
	logic hLast; // last byte of a command frame
	logic dReady; // device takes host byte
	logic rValid; // response byte offered
	logic [7:0] rByte; // response byte
	logic rLast; // last response byte
	logic rReady; // host takes response byte
	logic excPulse; // device raised an exception
	modport dev (input hValid, hByte, hLast, rReady,
		output dReady, rValid, rByte, rLast, excPulse);
	modport host (output hValid, hByte, hLast, rReady,
		input dReady, rValid, rByte, rLast, excPulse);
endinterface

// ===== rtl/rcf_host_end.sv
/*
 * host end: forwards user command frames over the link, collects answers.
 * assumes the user offers whole frames, code byte first.
 */
`timescale 1ns/1ps
module rcf_host_end
	import rcf_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	rcf_link_if.host link,
	input wire logic uValid,
	input wire logic [7:0] uByte,
	input wire logic uLast,
	output logic uReady,
	output logic uRefused,
	output logic rspValid,
	output logic [7:0] rspByte,
	output logic rspLast,
	output logic excSeen,
	output logic [7:0] lastCount
);
	import rcf_pkg::*;

	logic firstByte; // next user byte is a code byte
	logic dropping; // refused frame being swallowed
	logic countAsked; // a count query has been answered
	logic countPending; // waiting for a count answer
	logic refuseNow; // code byte that must not go out
	logic take; // user byte consumed

	// a read is only sent after a count answer; reserved code never goes out
	assign refuseNow = firstByte && (uByte == CMD_RESERVED ||
		(uByte == CMD_SET_READ && !countAsked));
	assign uReady = dropping || !link.hValid || link.dReady;
	assign take = ce && uValid && uReady;
	assign link.rReady = 1'b1; // host always drains answers

	// output byte stage; data leaves from a flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link.hValid <= 1'b0;
			link.hByte <= 8'h00;
			link.hLast <= 1'b0;
		end else if (ce) begin
			if (link.hValid && link.dReady) begin
				link.hValid <= 1'b0;
			end
			if (take && !dropping && !refuseNow) begin
				link.hValid <= 1'b1;
				link.hByte <= uByte;
				link.hLast <= uLast;
			end
		end
	end

	// frame tracking and refusal
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			firstByte <= 1'b1;
			dropping <= 1'b0;
			uRefused <= 1'b0;
		end else if (ce) begin
			uRefused <= 1'b0;
			if (take) begin
				firstByte <= uLast;
				if (refuseNow) begin
					uRefused <= 1'b1;
					dropping <= !uLast;
				end else if (uLast) begin
					dropping <= 1'b0;
				end
			end
		end
	end

	// count answer bookkeeping
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			countAsked <= 1'b0;
			countPending <= 1'b0;
			lastCount <= 8'h00;
		end else if (ce) begin
			if (take && firstByte && !refuseNow && uByte == CMD_SET_COUNT) begin
				countPending <= 1'b1;
				countAsked <= 1'b0;
			end else if (take && firstByte && uByte == CMD_SET_READ && countAsked) begin
				countAsked <= 1'b0; // each read needs a fresh count
			end
			if (countPending && link.rValid) begin
				countPending <= 1'b0;
				countAsked <= 1'b1;
				lastCount <= link.rByte;
			end else if (countPending && link.excPulse) begin
				countPending <= 1'b0;
			end
		end
	end

	// answers and exceptions handed to the user
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rspValid <= 1'b0;
			rspByte <= 8'h00;
			rspLast <= 1'b0;
			excSeen <= 1'b0;
		end else if (ce) begin
			rspValid <= link.rValid;
			rspByte <= link.rByte;
			rspLast <= link.rValid && link.rLast;
			excSeen <= link.excPulse;
		end
	end
endmodule

// ===== rtl/rcf_device_end.sv
/*
 * device end: parses host commands, updates and reads stored settings,
 * switches the field with its flags, and routes debug signals to pins.
 * assumes an external setting store that answers combinationally for the
 * selector and address it is shown, and writes on a one-cycle strobe.
 */
`timescale 1ns/1ps
module rcf_device_end
	import rcf_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	rcf_link_if.dev link,
	output logic [7:0] storeCfg,
	output logic [ADDR_W-1:0] storeAddr,
	input wire logic [7:0] storeCount,
	input wire logic [31:0] storeRdData,
	output logic storeWrEn,
	output logic [31:0] storeWrData,
	output logic fieldOn,
	output logic noCollAvoid,
	output logic activeMode,
	input wire logic fieldUpIrqEn,
	input wire logic fieldDownIrqEn,
	input wire logic fieldUpIrqClr,
	input wire logic fieldDownIrqClr,
	output logic fieldUpIrqFlag,
	output logic fieldDownIrqFlag,
	input wire logic debugBusAllow,
	input wire logic carrierClk,
	input wire logic [7:0] clockGroupSig,
	input wire logic [1:0] txEncGroupSig,
	output logic [DBG_PINS-1:0] debugPin,
	output logic [DBG_PINS-1:0] debugPinEn
);
	import rcf_pkg::*;

	rcf_state_t state; // parser state
	logic [7:0] code; // command being parsed
	logic [7:0] cfgSel; // selected setting
	logic [ADDR_W-1:0] regAddr; // element address, or pair index on reads
	logic [2:0] byteIdx; // byte within an element or pair
	logic [5:0] elemCnt; // elements or routing bytes seen
	logic [5:0] pairTotal; // pairs to send
	logic [23:0] wordLow; // low value bytes of an element
	logic [39:0] pairBuf; // outgoing bytes, low first
	logic pairFull; // pairBuf holds a pair or the count answer
	logic acc; // host byte taken
	logic rsp; // response byte taken
	logic fieldUpEvt; // field just came up
	logic fieldDownEvt; // field just went down
	logic [7:0] dbgGroup; // active group
	logic [3:0] routeSel [DBG_PINS]; // signal per pin
	logic [DBG_PINS-1:0] routeOn; // pin carries a signal
	logic [3:0] pendSel [DBG_PINS]; // routing being collected
	logic [DBG_PINS-1:0] pendOn;
	logic [7:0] pendGroup;
	logic [3:0] rtPin; // pin nibble of routing byte
	logic [3:0] rtSig; // signal nibble of routing byte
	logic lastPair; // pair index is on the final pair of a read

	assign link.dReady = (state != S_COUNT) && (state != S_READ);
	assign acc = ce && link.hValid && link.dReady;
	assign rsp = ce && link.rValid && link.rReady;
	assign link.rValid = pairFull;
	assign link.rByte = pairBuf[7:0];
	// pairTotal is never zero in the read state, so the wrap of the minus is unused
	assign lastPair = (regAddr == ADDR_W'(pairTotal - 6'd1));
	assign link.rLast = (state == S_COUNT) || (byteIdx == 3'd4 && lastPair);
	// count lookup sees the parameter byte as it arrives
	assign storeCfg = (state == S_PARAM) ? link.hByte : cfgSel;
	assign storeAddr = regAddr;
	assign rtPin = link.hByte[RT_PIN_LSB +: 4];
	assign rtSig = link.hByte[RT_SIG_LSB +: 4];

	// one selected signal of a group
	function automatic logic pickSig(input logic [7:0] grp, input logic [3:0] sel,
		input logic [7:0] clkSigs, input logic [1:0] txSigs, input logic car);
		pickSig = 1'b0;
		if (sel == SIG_CARRIER) begin
			pickSig = car;
		end else if (grp == GRP_CLOCK && sel < SIG_CARRIER) begin
			pickSig = clkSigs[sel[2:0]];
		end else if (grp == GRP_TX_ENC && (sel == TXE_ENVELOPE || sel == TXE_IRQ)) begin
			pickSig = txSigs[sel[0]];
		end
	endfunction

	// command parser
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= S_CMD;
			code <= 8'h00;
			cfgSel <= 8'h00;
			regAddr <= '0;
			byteIdx <= 3'd0;
			elemCnt <= 6'd0;
			pairTotal <= 6'd0;
			wordLow <= 24'h0;
			pairBuf <= 40'h0;
			pairFull <= 1'b0;
			link.excPulse <= 1'b0;
			storeWrEn <= 1'b0;
			storeWrData <= 32'h0;
		end else if (ce) begin
			link.excPulse <= 1'b0;
			storeWrEn <= 1'b0;
			unique case (state)
				S_CMD: if (acc) begin
					code <= link.hByte;
					byteIdx <= 3'd0;
					elemCnt <= 6'd0;
					if (link.hByte == CMD_RESERVED) begin
						state <= link.hLast ? S_CMD : S_DRAIN;
					end else if (link.hByte == CMD_SET_WRITE) begin
						link.excPulse <= link.hLast;
						state <= link.hLast ? S_CMD : S_WRITE;
					end else if (link.hByte == CMD_DBG_ROUTE) begin
						link.excPulse <= link.hLast;
						state <= link.hLast ? S_CMD : S_ROUTE;
					end else if (link.hByte >= CMD_SET_COUNT && link.hByte <= CMD_FIELD_OFF) begin
						link.excPulse <= link.hLast;
						state <= link.hLast ? S_CMD : S_PARAM;
					end else begin
						link.excPulse <= 1'b1; // not handled here
						state <= link.hLast ? S_CMD : S_DRAIN;
					end
				end
				S_WRITE: if (acc) begin
					byteIdx <= (byteIdx == 3'd5) ? 3'd0 : byteIdx + 3'd1;
					if (byteIdx == 3'd0) begin
						cfgSel <= link.hByte;
					end else if (byteIdx == 3'd1) begin
						regAddr <= link.hByte[ADDR_W-1:0];
					end else if (byteIdx != 3'd5) begin
						wordLow <= {link.hByte, wordLow[23:8]};
					end
					if (byteIdx == 3'd5) begin
						elemCnt <= elemCnt + 6'd1;
						if (!cfgIdOk(cfgSel) || {8'h00, regAddr} >= {8'h00, storeCount} ||
							elemCnt >= 6'(WR_ELEM_MAX)) begin
							link.excPulse <= 1'b1;
							state <= link.hLast ? S_CMD : S_DRAIN;
						end else begin
							storeWrEn <= 1'b1;
							storeWrData <= {link.hByte, wordLow};
							if (link.hLast) begin
								state <= S_CMD;
							end
						end
					end else if (link.hLast) begin
						link.excPulse <= 1'b1; // partial element
						state <= S_CMD;
					end
				end
				S_PARAM: if (acc) begin
					state <= link.hLast ? S_CMD : S_DRAIN;
					link.excPulse <= !link.hLast; // surplus parameter bytes
					if (link.hLast && (code == CMD_SET_COUNT || code == CMD_SET_READ)) begin
						if (!cfgIdOk(link.hByte)) begin
							link.excPulse <= 1'b1;
						end else if (code == CMD_SET_COUNT) begin
							pairBuf <= {32'h0, storeCount};
							pairFull <= 1'b1;
							state <= S_COUNT;
						end else if (storeCount != 8'h00) begin
							cfgSel <= link.hByte;
							regAddr <= '0;
							pairTotal <= (storeCount > 8'(RD_PAIR_MAX)) ?
								6'(RD_PAIR_MAX) : storeCount[5:0];
							state <= S_READ;
						end
					end
				end
				S_COUNT: if (rsp) begin
					pairFull <= 1'b0;
					state <= S_CMD;
				end
				S_READ: if (!pairFull) begin
					pairBuf <= {storeRdData, 8'(regAddr)};
					pairFull <= 1'b1;
					byteIdx <= 3'd0;
				end else if (rsp) begin
					pairBuf <= {8'h00, pairBuf[39:8]};
					byteIdx <= byteIdx + 3'd1;
					if (byteIdx == 3'd4) begin
						pairFull <= 1'b0;
						regAddr <= regAddr + 1'b1;
						if (lastPair) begin
							state <= S_CMD;
						end
					end
				end
				S_ROUTE: if (acc) begin
					elemCnt <= elemCnt + 6'd1;
					if (elemCnt > 6'(ROUTE_MAX)) begin
						link.excPulse <= 1'b1;
						state <= link.hLast ? S_CMD : S_DRAIN;
					end else if (link.hLast) begin
						link.excPulse <= (elemCnt == 6'd0); // group byte only
						state <= S_CMD;
					end
				end
				S_DRAIN: if (acc && link.hLast) begin
					state <= S_CMD;
				end
				default: state <= S_CMD;
			endcase
		end
	end

	// field control and its one-cycle events
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fieldOn <= 1'b0;
			noCollAvoid <= 1'b0;
			activeMode <= 1'b0;
			fieldUpEvt <= 1'b0;
			fieldDownEvt <= 1'b0;
		end else if (ce) begin
			fieldUpEvt <= 1'b0;
			fieldDownEvt <= 1'b0;
			if (state == S_PARAM && acc && link.hLast && code == CMD_FIELD_ON) begin
				fieldOn <= 1'b1;
				noCollAvoid <= link.hByte[FLD_NO_COLL_BIT];
				activeMode <= link.hByte[FLD_ACTIVE_BIT];
				fieldUpEvt <= 1'b1;
			end
			if (state == S_PARAM && acc && link.hLast && code == CMD_FIELD_OFF) begin
				fieldOn <= 1'b0; // parameter value ignored
				fieldDownEvt <= 1'b1;
			end
		end
	end

	// sticky flags; a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fieldUpIrqFlag <= 1'b0;
			fieldDownIrqFlag <= 1'b0;
		end else if (ce) begin
			fieldUpIrqFlag <= (fieldUpEvt && fieldUpIrqEn) ||
				(fieldUpIrqFlag && !fieldUpIrqClr);
			fieldDownIrqFlag <= (fieldDownEvt && fieldDownIrqEn) ||
				(fieldDownIrqFlag && !fieldDownIrqClr);
		end
	end

	// route collection; committed as a whole when the frame ends cleanly
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pendGroup <= GROUP_RESET;
			pendOn <= '0;
			dbgGroup <= GROUP_RESET;
			routeOn <= '0;
			for (int i = 0; i < DBG_PINS; i++) begin
				pendSel[i] <= 4'h0;
				routeSel[i] <= 4'h0;
			end
		end else if (ce && state == S_ROUTE && acc) begin
			if (elemCnt == 6'd0) begin
				pendGroup <= link.hByte;
				pendOn <= '0;
			end else if (elemCnt <= 6'(ROUTE_MAX)) begin
				// reserved pins and signals leave the pin unrouted
				if (rtPin < PIN_COUNT && rtSig <= SIG_CARRIER) begin
					pendSel[rtPin[1:0]] <= rtSig;
					pendOn[rtPin[1:0]] <= 1'b1;
				end
				if (link.hLast) begin
					dbgGroup <= pendGroup;
					routeOn <= pendOn;
					for (int i = 0; i < DBG_PINS; i++) begin
						routeSel[i] <= pendSel[i];
					end
					if (rtPin < PIN_COUNT && rtSig <= SIG_CARRIER) begin
						routeOn[rtPin[1:0]] <= 1'b1;
						routeSel[rtPin[1:0]] <= rtSig;
					end
				end
			end
		end
	end

	// each pin sampled on its own; one cycle of latency, carrier included
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			debugPin <= '0;
			debugPinEn <= '0;
		end else if (ce) begin
			for (int i = 0; i < DBG_PINS; i++) begin
				debugPinEn[i] <= debugBusAllow && routeOn[i];
				debugPin[i] <= debugBusAllow && routeOn[i] &&
					pickSig(dbgGroup, routeSel[i], clockGroupSig, txEncGroupSig, carrierClk);
			end
		end
	end
endmodule

// ===== dv/rcf_link_properties.sv
/*
 * concurrent checks on the byte link between the host end and the device end.
 * assumes one clock, synchronous active-low reset and clock enable held high.
 */
`timescale 1ns/1ps
module rcf_link_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hValid,
	input wire logic [7:0] hByte,
	input wire logic hLast,
	input wire logic dReady,
	input wire logic rValid,
	input wire logic [7:0] rByte,
	input wire logic rLast,
	input wire logic rReady,
	input wire logic excPulse
);
	logic take; // a host byte moves at this edge
	logic selOk; // live byte is a legal selector
	logic first; // next byte taken opens a frame
	logic faulted; // frame already raised an exception
	logic [7:0] code; // code byte of the frame
	logic [5:0] pCnt; // parameter bytes taken, saturating
	logic [2:0] ePos; // byte position inside a write element
	logic mid; // a parameter byte, not a code byte
	logic selBad; // selector of the element being collected is out of range
	assign take = hValid && dReady;
	assign mid = take && !first;
	assign selOk = hByte <= 8'h1c || (hByte >= 8'h80 && hByte <= 8'h9c);
	// frame tracker; it follows positions only, never the parser's verdicts
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			first <= 1'b1;
			code <= 8'h00;
			pCnt <= 6'h00;
			ePos <= 3'h0;
			selBad <= 1'b0;
		end else if (take) begin
			first <= hLast;
			code <= first ? hByte : code;
			pCnt <= first ? 6'h00 : (pCnt == 6'h3f ? pCnt : pCnt + 6'h01);
			ePos <= (first || ePos == 3'h5) ? 3'h0 : ePos + 3'h1;
			// the parser judges an element only once its last value byte is in
			selBad <= (!first && ePos == 3'h0) ? !selOk : selBad;
		end
	end
	// remembers an exception so later bytes of a drained frame are not judged
	always_ff @(posedge clk) begin
		if (!rst_n || (take && first)) begin
			faulted <= 1'b0;
		end else if (excPulse) begin
			faulted <= 1'b1;
		end
	end
	default clocking dcb @(posedge clk); endclocking
	default disable iff (!rst_n);
	count_answer_a: assert property (mid && hLast && code == 8'h13 && pCnt == 6'h00 && selOk
		|=> rValid && rLast) else $error("count answer not offered");
	bad_id_a: assert property (mid && hLast && (code == 8'h13 || code == 8'h14) && pCnt == 6'h00
		&& !selOk |=> excPulse && !rValid) else $error("bad selector not refused");
	read_start_a: assert property (mid && hLast && code == 8'h14 && pCnt == 6'h00 && selOk
		|=> !rValid && !excPulse) else $error("read did not start with a load cycle");
	busy_refuse_a: assert property (rValid |-> !dReady) else $error("byte taken while answering");
	answer_end_a: assert property (rValid && rLast && rReady |=> !rValid)
		else $error("answer ran past its last byte");
	missing_param_a: assert property (take && first && hLast && hByte inside {8'h12, 8'h13,
		8'h14, 8'h16, 8'h17, 8'h18} |=> excPulse) else $error("missing parameter not refused");
	unknown_code_a: assert property (take && first && !(hByte inside {[8'h12:8'h18]})
		|=> excPulse) else $error("unknown code not refused");
	field_quiet_a: assert property (mid && hLast && (code == 8'h16 || code == 8'h17)
		&& pCnt == 6'h00 |=> !excPulse && !rValid) else $error("field command answered");
	group_only_a: assert property (mid && hLast && code == 8'h18 && pCnt == 6'h00
		|=> excPulse) else $error("route without routing byte accepted");
	partial_elem_a: assert property (mid && hLast && code == 8'h12 && ePos != 3'h5
		&& !faulted && !excPulse |=> excPulse) else $error("partial element accepted");
	bad_sel_a: assert property (mid && code == 8'h12 && ePos == 3'h5 && selBad && !faulted
		&& !excPulse |=> excPulse) else $error("bad write selector accepted");
	cover property (take && first && hByte == 8'h14);
	cover property (rValid && rLast && rByte == 8'h26);
	cover property (excPulse);
	cover property (mid && hLast && code == 8'h18);
endmodule

// ===== dv/tb.sv
/*
 * testbench: host end and device end joined by the link interface, a
 * behavioural setting store, and the link checker beside the interface.
 * assumes clock enable stays high and the store answers in the same cycle.
 */
`timescale 1ns/1ps
module tb;
	import rcf_pkg::*;
	logic clk = 1'b0; // 100 MHz
	logic rst_n = 1'b0; // sync, active low
	logic uValid = 1'b0; // user frame stream
	logic [7:0] uByte = 8'h00;
	logic uLast = 1'b0;
	logic uReady, uRefused, rspValid, rspLast, excSeen, storeWrEn;
	logic [7:0] rspByte, lastCount, storeCfg, storeAddr, storeCount;
	logic [31:0] storeRdData, storeWrData;
	logic fieldOn, noCollAvoid, activeMode, fieldUpIrqFlag, fieldDownIrqFlag;
	logic fieldUpIrqEn = 1'b0, fieldDownIrqEn = 1'b0, fieldUpIrqClr = 1'b0, fieldDownIrqClr = 1'b0;
	logic debugBusAllow = 1'b0; // stored debug enable, off at first
	logic carrierClk = 1'b1; // held still so pins compare exactly
	logic [7:0] clockGroupSig = 8'ha0; // codes 7 and 5 high, 6 low
	logic [1:0] txEncGroupSig = 2'b10; // envelope high, tx irq low
	logic [3:0] debugPin, debugPinEn;
	logic [7:0] rspQ[$]; // answer bytes seen
	logic [47:0] wrQ[$]; // store writes seen
	int excN, refN, lastN, miscompares, numChecks, cycles;
	always #5 clk = ~clk;
	// store: 40 registers at selector 0x80, 3 elsewhere; content names address and selector
	assign storeCount = (storeCfg == 8'h80) ? 8'h28 : 8'h03;
	assign storeRdData = {storeAddr, 8'hc3, storeCfg, 8'h5a};
	rcf_link_if u_rcf_link_if();
	rcf_host_end u_rcf_host_end(.clk, .rst_n, .ce(1'b1), .link(u_rcf_link_if.host), .uValid,
		.uByte, .uLast, .uReady, .uRefused, .rspValid, .rspByte, .rspLast, .excSeen, .lastCount);
	rcf_device_end u_rcf_device_end(.clk, .rst_n, .ce(1'b1), .link(u_rcf_link_if.dev), .storeCfg,
		.storeAddr, .storeCount, .storeRdData, .storeWrEn, .storeWrData, .fieldOn, .noCollAvoid,
		.activeMode, .fieldUpIrqEn, .fieldDownIrqEn, .fieldUpIrqClr, .fieldDownIrqClr,
		.fieldUpIrqFlag, .fieldDownIrqFlag, .debugBusAllow, .carrierClk, .clockGroupSig,
		.txEncGroupSig, .debugPin, .debugPinEn);
	rcf_link_properties u_rcf_link_properties(.clk, .rst_n, .hValid(u_rcf_link_if.hValid),
		.hByte(u_rcf_link_if.hByte), .hLast(u_rcf_link_if.hLast), .dReady(u_rcf_link_if.dReady),
		.rValid(u_rcf_link_if.rValid), .rByte(u_rcf_link_if.rByte), .rLast(u_rcf_link_if.rLast),
		.rReady(u_rcf_link_if.rReady), .excPulse(u_rcf_link_if.excPulse));
	// monitor of pulses and answers, plus the hang limit
	always @(posedge clk) begin
		cycles++;
		if (rspValid === 1'b1) rspQ.push_back(rspByte);
		if (rspValid === 1'b1 && rspLast === 1'b1) lastN++;
		if (excSeen === 1'b1) excN++;
		if (uRefused === 1'b1) refN++;
		if (storeWrEn === 1'b1) wrQ.push_back({storeCfg, storeAddr, storeWrData});
		if (cycles == 20000) begin
			miscompares++;
			$display("MISMATCH %0t run hung", $time);
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		numChecks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	// one frame; each byte held until the host end takes it
	task automatic send(input logic [7:0] b[$]);
		for (int i = 0; i < b.size(); i++) begin
			uValid <= 1'b1;
			uByte <= b[i];
			uLast <= (i == b.size() - 1);
			do @(negedge clk); while (uReady !== 1'b1);
			@(posedge clk);
		end
		uValid <= 1'b0;
		uLast <= 1'b0;
	endtask
	task automatic run(input logic [7:0] b[$], input int waitN, input int expExc, input int expRsp);
		excN = 0;
		refN = 0;
		rspQ = {};
		lastN = 0;
		wrQ = {};
		send(b);
		repeat (waitN) @(posedge clk);
		chk(excN == expExc, "exception count");
		chk(rspQ.size() == expRsp, "answer length");
		chk(lastN == ((expRsp > 0) ? 1 : 0), "answer end mark");
	endtask
	task automatic test_write();
		logic [7:0] b[$];
		b = '{8'h12, 8'h05, 8'h01, 8'h44, 8'h33, 8'h22, 8'h11, 8'h85, 8'h02, 8'hd4, 8'hc3, 8'hb2, 8'ha1};
		run(b, 6, 0, 0);
		chk(wrQ.size() == 2 && wrQ[0] === 48'h0501_11223344, "first write");
		chk(wrQ[1] === 48'h8502_a1b2c3d4, "second write");
		run('{8'h12, 8'h1d, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04}, 6, 1, 0);
		run('{8'h12, 8'h05, 8'h03, 8'h01, 8'h02, 8'h03, 8'h04}, 6, 1, 0);
		chk(wrQ.size() == 0, "faulty element written");
		run('{8'h12, 8'h05, 8'h01, 8'haa}, 6, 1, 0);
		run('{8'h12}, 6, 1, 0);
		b = '{8'h12};
		for (int i = 0; i < 42; i++) b = {b, 8'h00, 8'h02, 8'h01, 8'h02, 8'h03, 8'h04};
		run(b, 6, 0, 0);
		chk(wrQ.size() == 42, "forty-two elements");
		b = {b, 8'h00, 8'h02, 8'h01, 8'h02, 8'h03, 8'h04};
		run(b, 6, 1, 0);
		chk(wrQ.size() == 42, "good elements kept");
		$display("test write done");
	endtask
	task automatic test_count_read();
		logic [7:0] bad[4] = '{8'h1d, 8'h7f, 8'h9d, 8'hff};
		run('{8'h13, 8'h05}, 6, 0, 1);
		chk(rspQ[0] === 8'h03 && lastCount === 8'h03, "count of 0x05");
		foreach (bad[i]) run('{8'h13, bad[i]}, 6, 1, 0);
		run('{8'h13, 8'h80}, 6, 0, 1);
		chk(rspQ[0] === 8'h28, "count of 0x80");
		run('{8'h14, 8'h80}, 300, 0, 195);
		chk(rspQ[0] === 8'h00 && rspQ[1] === 8'h5a && rspQ[2] === 8'h80, "first pair");
		chk(rspQ[3] === 8'hc3 && rspQ[4] === 8'h00 && rspQ[190] === 8'h26, "pair order");
		run('{8'h14, 8'h80}, 6, 0, 0);
		chk(refN == 1, "read without count");
		run('{8'h13, 8'h05}, 6, 0, 1);
		run('{8'h14, 8'h1d}, 6, 1, 0);
		run('{8'h15}, 6, 0, 0);
		chk(refN == 1, "reserved code");
		run('{8'h20}, 6, 1, 0);
		$display("test count and read done");
	endtask
	task automatic test_field();
		fieldUpIrqEn <= 1'b1;
		run('{8'h16, 8'h01}, 6, 0, 0);
		chk(fieldOn === 1'b1 && noCollAvoid === 1'b1 && activeMode === 1'b0, "field bit0");
		chk(fieldUpIrqFlag === 1'b1, "up flag");
		fieldUpIrqClr <= 1'b1;
		fieldUpIrqEn <= 1'b0;
		@(posedge clk);
		fieldUpIrqClr <= 1'b0;
		run('{8'h16, 8'h02}, 6, 0, 0);
		chk(noCollAvoid === 1'b0 && activeMode === 1'b1, "field bit1");
		chk(fieldUpIrqFlag === 1'b0, "masked up flag");
		fieldDownIrqEn <= 1'b1;
		run('{8'h17, 8'ha5}, 6, 0, 0);
		chk(fieldOn === 1'b0 && fieldDownIrqFlag === 1'b1, "field off");
		run('{8'h16}, 6, 1, 0);
		$display("test field done");
	endtask
	task automatic test_route();
		logic [7:0] grp[5] = '{8'h1d, 8'h30, 8'h58, 8'h70, 8'h73};
		run('{8'h18, 8'h01, 8'h07, 8'h16, 8'h25, 8'h38}, 6, 0, 0);
		chk(debugPinEn === 4'h0, "pins driven while not allowed");
		debugBusAllow <= 1'b1;
		repeat (3) @(posedge clk);
		chk(debugPinEn === 4'hf && debugPin === 4'hd, "clock group");
		carrierClk <= 1'b0;
		repeat (3) @(posedge clk);
		chk(debugPin === 4'h5, "carrier follows");
		run('{8'h18, 8'h1b, 8'h01, 8'h10, 8'h49}, 6, 0, 0);
		chk(debugPinEn === 4'h3 && debugPin[1:0] === 2'b01, "encoder group");
		run('{8'h18, 8'h1b}, 6, 1, 0);
		run('{8'h18, 8'h1b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 6, 1, 0);
		chk(debugPinEn === 4'h3 && debugPin[1:0] === 2'b01, "routing kept");
		carrierClk <= 1'b1;
		foreach (grp[i]) begin
			run('{8'h18, grp[i], 8'h08, 8'h10}, 6, 0, 0);
			chk(debugPinEn === 4'h3 && debugPin[1:0] === 2'b01, "group carrier");
		end
		$display("test route done");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		test_write();
		test_count_read();
		test_field();
		test_route();
		stop_test();
	end
endmodule
